// ===== rtl/sewp_defines.svh
/*
  constants of the serial eeprom command and write-protect block: opcodes, status
  bit positions, reset values and programming time.
  assumes: included by bare name from the package and the design modules.
*/
`ifndef SEWP_DEFINES_SVH
`define SEWP_DEFINES_SVH

`define SEWP_MEM_BYTES 4096
`define SEWP_PAGE_BYTES 32

`define SEWP_OPC_MASK 8'hF7
`define SEWP_OPC_READ 8'h03
`define SEWP_OPC_WRITE 8'h02
`define SEWP_OPC_ARM 8'h06
`define SEWP_OPC_DISARM 8'h04
`define SEWP_OPC_SRD 8'h05
`define SEWP_OPC_SWR 8'h01

`define SEWP_SR_ARM_BIT 7
`define SEWP_SR_GUARD_HI_BIT 3
`define SEWP_SR_GUARD_LO_BIT 2
`define SEWP_SR_LATCH_BIT 1
`define SEWP_SR_BUSY_BIT 0
`define SEWP_SR_BUSY_VAL 8'hFF

`define SEWP_ARM_RST 1'b0
`define SEWP_GUARD_RST 2'h0
`define SEWP_LATCH_RST 1'b0
`define SEWP_CS_IDLE 1'b1

`define SEWP_PROG_TIME_MS 5
`define SEWP_MCLK_HZ 25000000
`define SEWP_PROG_CYCLES ((`SEWP_PROG_TIME_MS * `SEWP_MCLK_HZ) / 1000)

`endif

// ===== rtl/sewp_pkg.sv
/*
  types of the serial eeprom block: link phase and programming state.
  assumes: nothing beyond the defines header.
*/
`default_nettype none
`include "sewp_defines.svh"
package sewp_pkg;
  typedef enum logic [2:0] {
    ph_opc = 3'b000,
    ph_adr = 3'b001,
    ph_din = 3'b010,
    ph_dout = 3'b011,
    ph_srout = 3'b100,
    ph_srin = 3'b101,
    ph_skip = 3'b110
  } sewp_phase_e;

  typedef enum logic [1:0] {
    pg_idle = 2'b00,
    pg_fetch = 2'b01,
    pg_store = 2'b10,
    pg_wait = 2'b11
  } sewp_prog_e;
endpackage : sewp_pkg
`default_nettype wire

// ===== rtl/sewp_ram_if.sv
/*
  interface between the block and its memories: one write port and one registered read port.
  assumes: the two clocks are supplied to the memory module directly.
*/
`timescale 1ns/1ns
`default_nettype none
interface sewp_ram_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : sewp_ram_if
`default_nettype wire

// ===== rtl/sewp_ram.sv
/*
  simple dual port memory, write on one clock, registered read on another.
  assumes: no read and write of the same word at the same time.
*/
`timescale 1ns/1ns
`default_nettype none
module sewp_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic wr_clk,
  input wire logic rd_clk,
  sewp_ram_if.mem port
);
  logic [DW-1:0] mem_reg [2**AW];
  logic [DW-1:0] rd_reg;

  always_ff @(posedge wr_clk) begin
    if (port.wr_en) begin
      mem_reg[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (port.rd_en) begin
      rd_reg <= mem_reg[port.rd_addr];
    end
  end

  assign port.rd_data = rd_reg;
endmodule : sewp_ram
`default_nettype wire

// ===== rtl/sewp_top.sv
/*
  spi slave side of a serial eeprom: command decode, write latch, protect logic,
  page buffer, self-timed programming and sequential read.
  assumes: sck runs only while cs_n is low, spi mode 0; cs_n stays high for at
  least four mclk cycles between frames; mclk at 25 MHz.
*/
// How it works
// - latch clear refuses every programming request
// - armed and pin low: array only
// - unarmed or pin high: array and status
// - small variant guard ranges by quarter
// - large variant guard ranges by quarter
// - guarded locations are never programmed
// - programming starts on chip select rise
// - status bit 0 shows busy
// - status read while busy gives FF
// - only status read accepted while busy
// - up to 32 bytes per cycle
// - page column wraps within page
// - every write command decoded while not busy clears the latch
// - write without latch discarded until reselect
// - read address increments per byte
// - read address wraps to zero
// - input ignored after read address
// - programming cycle lasts at most 5 ms
// - opcode bit 3, address top bits ignored
// - status layout arm, guard, latch, busy
// - sample on rise, msb first
// - pause pin freezes sck edges
`timescale 1ns/1ns
`default_nettype none
`include "sewp_defines.svh"
module sewp_top #(
  parameter int MEM_BYTES = `SEWP_MEM_BYTES,
  parameter int PAGE_BYTES = `SEWP_PAGE_BYTES,
  parameter int PROG_CYCLES = `SEWP_PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic busy
);
  import sewp_pkg::*;
  localparam int AW = $clog2(MEM_BYTES);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(PROG_CYCLES);

  if (MEM_BYTES != (1 << AW) || AW > 16 || AW < 4 || PAGE_BYTES != (1 << PW) ||
      PAGE_BYTES * 4 > MEM_BYTES || PROG_CYCLES < 2 * PAGE_BYTES + 4) begin : g_bad
    $error("sewp_top: unsupported size or programming count");
  end

  // quarter-based guard decode: top quarter, top half or whole array
  function automatic logic is_guarded(input logic [1:0] g, input logic [AW-1:0] a);
    case (g)
      2'h0: is_guarded = 1'b0;
      2'h1: is_guarded = (a[AW-1:AW-2] == 2'h3);
      2'h2: is_guarded = a[AW-1];
      default: is_guarded = 1'b1;
    endcase
  endfunction : is_guarded

  sewp_ram_if #(.AW(AW), .DW(8)) arr ();
  sewp_ram_if #(.AW(PW), .DW(8)) pbuf ();

  sewp_ram #(.AW(AW), .DW(8)) u_array (.wr_clk(mclk), .rd_clk(sck), .port(arr));
  sewp_ram #(.AW(PW), .DW(8)) u_page (.wr_clk(sck), .rd_clk(mclk), .port(pbuf));

  // sck domain: frame state is cleared whenever chip select is high
  wire frame_rst_n = rstn & ~cs_n;
  wire oe_rst_n = rstn & ~cs_n & hold_n;

  sewp_phase_e ph_reg, ph_next;
  logic [2:0] bit_reg, bit_next;
  logic [6:0] sh_reg, sh_next;
  logic [7:0] adr_hi_reg, adr_hi_next;
  logic adr2_reg, adr2_next, wr_reg, wr_next, load_reg, load_next;
  logic [AW-1:0] adr_reg, adr_next;
  logic [PW-1:0] col_reg, col_next;

  logic latch_reg, latch_next, pend_reg, pend_next, sr_flag_reg, sr_flag_next;
  logic [7:0] sr_new_reg, sr_new_next;
  logic [PAGE_BYTES-1:0] valid_reg, valid_next;
  logic [AW-PW-1:0] base_reg, base_next;
  logic busy_s1, busy_s2, arm_s1, arm_s2, wp_s1, wp_s2;
  logic [1:0] guard_s1, guard_s2;

  logic [7:0] byte_in, op, st_byte, src;
  logic [15:0] full_adr;
  logic so_next, oe_next;
  logic [6:0] out_sh_reg, out_sh_next;

  // mclk domain state, declared here for the status byte
  logic arm_reg, arm_next;
  logic [1:0] guard_reg, guard_next;

  always_comb begin
    byte_in = {sh_reg, si};
    op = byte_in & `SEWP_OPC_MASK;
    full_adr = {adr_hi_reg, byte_in};
    st_byte = 8'h00;
    st_byte[`SEWP_SR_ARM_BIT] = arm_s2;
    st_byte[`SEWP_SR_GUARD_HI_BIT] = guard_s2[1];
    st_byte[`SEWP_SR_GUARD_LO_BIT] = guard_s2[0];
    st_byte[`SEWP_SR_LATCH_BIT] = latch_reg;
    st_byte[`SEWP_SR_BUSY_BIT] = busy_s2;
    if (busy_s2) begin
      st_byte = `SEWP_SR_BUSY_VAL;
    end
    ph_next = ph_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    adr_hi_next = adr_hi_reg;
    adr2_next = adr2_reg;
    wr_next = wr_reg;
    load_next = load_reg;
    adr_next = adr_reg;
    col_next = col_reg;
    latch_next = latch_reg;
    pend_next = pend_reg;
    sr_flag_next = sr_flag_reg;
    sr_new_next = sr_new_reg;
    valid_next = valid_reg;
    base_next = base_reg;
    arr.rd_en = 1'b0;
    arr.rd_addr = adr_reg;
    pbuf.wr_en = 1'b0;
    pbuf.wr_addr = col_reg;
    pbuf.wr_data = byte_in;
    if (hold_n) begin
      bit_next = bit_reg + 3'h1;
      sh_next = byte_in[6:0];
      pend_next = 1'b0;
      load_next = 1'b0;
      if (bit_reg == 3'h7) begin
        case (ph_reg)
          ph_opc: begin
            ph_next = ph_skip;
            if (op == `SEWP_OPC_SRD) begin
              ph_next = ph_srout;
              load_next = 1'b1;
            end else if (!busy_s2) begin
              case (op)
                `SEWP_OPC_READ: begin
                  ph_next = ph_adr;
                  wr_next = 1'b0;
                end
                `SEWP_OPC_WRITE: begin
                  latch_next = 1'b0;
                  if (latch_reg) begin
                    ph_next = ph_adr;
                    wr_next = 1'b1;
                    valid_next = '0;
                    sr_flag_next = 1'b0;
                  end
                end
                `SEWP_OPC_ARM: latch_next = 1'b1;
                `SEWP_OPC_DISARM: latch_next = 1'b0;
                `SEWP_OPC_SWR: begin
                  latch_next = 1'b0;
                  if (latch_reg && (!arm_s2 || wp_s2)) begin
                    ph_next = ph_srin;
                    valid_next = '0;
                    sr_flag_next = 1'b1;
                  end
                end
                default: ph_next = ph_skip;
              endcase
            end
          end
          ph_adr: begin
            if (!adr2_reg) begin
              adr_hi_next = byte_in;
              adr2_next = 1'b1;
            end else if (wr_reg) begin
              base_next = full_adr[AW-1:PW];
              col_next = full_adr[PW-1:0];
              ph_next = ph_din;
            end else begin
              adr_next = full_adr[AW-1:0];
              arr.rd_en = 1'b1;
              arr.rd_addr = full_adr[AW-1:0];
              load_next = 1'b1;
              ph_next = ph_dout;
            end
          end
          ph_din: begin
            // latch was judged at the opcode; guard is judged per byte
            if (!is_guarded(guard_s2, {base_reg, col_reg})) begin
              pbuf.wr_en = 1'b1;
              valid_next[col_reg] = 1'b1;
            end
            col_next = col_reg + PW'(1);
            pend_next = 1'b1;
          end
          ph_srin: begin
            sr_new_next = byte_in;
            pend_next = 1'b1;
            ph_next = ph_skip;
          end
          ph_dout: begin
            adr_next = adr_reg + AW'(1);
            arr.rd_en = 1'b1;
            arr.rd_addr = adr_reg + AW'(1);
            load_next = 1'b1;
          end
          ph_srout: load_next = 1'b1;
          default: ph_next = ph_skip;
        endcase
      end
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_reg <= ph_opc;
      bit_reg <= 3'h0;
      sh_reg <= 7'h00;
      adr_hi_reg <= 8'h00;
      adr2_reg <= 1'b0;
      wr_reg <= 1'b0;
      load_reg <= 1'b0;
      adr_reg <= '0;
      col_reg <= '0;
    end else begin
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      adr_hi_reg <= adr_hi_next;
      adr2_reg <= adr2_next;
      wr_reg <= wr_next;
      load_reg <= load_next;
      adr_reg <= adr_next;
      col_reg <= col_next;
    end
  end

  // these survive chip select; buffer, base and flags are read by mclk only after
  // the frame has ended and sck is still, so they are static when sampled
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= `SEWP_LATCH_RST;
      pend_reg <= 1'b0;
      sr_flag_reg <= 1'b0;
      sr_new_reg <= 8'h00;
      valid_reg <= '0;
      base_reg <= '0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      arm_s1 <= `SEWP_ARM_RST;
      arm_s2 <= `SEWP_ARM_RST;
      guard_s1 <= `SEWP_GUARD_RST;
      guard_s2 <= `SEWP_GUARD_RST;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      pend_reg <= pend_next;
      sr_flag_reg <= sr_flag_next;
      sr_new_reg <= sr_new_next;
      valid_reg <= valid_next;
      base_reg <= base_next;
      busy_s1 <= busy;
      busy_s2 <= busy_s1;
      arm_s1 <= arm_reg;
      arm_s2 <= arm_s1;
      guard_s1 <= guard_reg;
      guard_s2 <= guard_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  // output side on the falling edge, so the master samples on the next rise
  always_comb begin
    src = (ph_reg == ph_srout) ? st_byte : arr.rd_data;
    so_next = so;
    out_sh_next = out_sh_reg;
    oe_next = (ph_reg == ph_dout) || (ph_reg == ph_srout);
    if (hold_n) begin
      if (load_reg) begin
        {so_next, out_sh_next} = src;
      end else begin
        {so_next, out_sh_next} = {out_sh_reg, 1'b0};
      end
    end
  end

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so <= 1'b0;
      out_sh_reg <= 7'h00;
    end else begin
      so <= so_next;
      out_sh_reg <= out_sh_next;
    end
  end

  // released pin only after a falling edge, so a paused frame stays quiet
  always_ff @(negedge sck or negedge oe_rst_n) begin
    if (!oe_rst_n) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= oe_next;
    end
  end

  // mclk domain: programming engine
  sewp_prog_e pg_reg, pg_next;
  logic [PW-1:0] idx_reg, idx_next;
  logic [TW-1:0] tmr_reg, tmr_next;
  logic busy_next;
  logic cs_s1, cs_s2, cs_s3, pend_s1, pend_s2;
  logic start;

  always_comb begin
    start = cs_s2 && !cs_s3 && pend_s2 && (pg_reg == pg_idle);
    pg_next = pg_reg;
    idx_next = idx_reg;
    tmr_next = tmr_reg + TW'(1);
    busy_next = busy;
    arm_next = arm_reg;
    guard_next = guard_reg;
    pbuf.rd_en = 1'b0;
    pbuf.rd_addr = idx_reg;
    arr.wr_en = 1'b0;
    arr.wr_addr = {base_reg, idx_reg};
    arr.wr_data = pbuf.rd_data;
    case (pg_reg)
      pg_idle: begin
        tmr_next = '0;
        if (start) begin
          busy_next = 1'b1;
          idx_next = '0;
          if (sr_flag_reg) begin
            arm_next = sr_new_reg[`SEWP_SR_ARM_BIT];
            guard_next = {sr_new_reg[`SEWP_SR_GUARD_HI_BIT], sr_new_reg[`SEWP_SR_GUARD_LO_BIT]};
            pg_next = pg_wait;
          end else begin
            pg_next = pg_fetch;
          end
        end
      end
      pg_fetch: begin
        pbuf.rd_en = 1'b1;
        pg_next = pg_store;
      end
      pg_store: begin
        arr.wr_en = valid_reg[idx_reg];
        idx_next = idx_reg + PW'(1);
        pg_next = (idx_reg == PW'(PAGE_BYTES - 1)) ? pg_wait : pg_fetch;
      end
      pg_wait: begin
        if (tmr_reg == TW'(PROG_CYCLES - 1)) begin
          busy_next = 1'b0;
          pg_next = pg_idle;
        end
      end
      default: pg_next = pg_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pg_reg <= pg_idle;
      idx_reg <= '0;
      tmr_reg <= '0;
      busy <= 1'b0;
      arm_reg <= `SEWP_ARM_RST;
      guard_reg <= `SEWP_GUARD_RST;
      cs_s1 <= `SEWP_CS_IDLE;
      cs_s2 <= `SEWP_CS_IDLE;
      cs_s3 <= `SEWP_CS_IDLE;
      pend_s1 <= 1'b0;
      pend_s2 <= 1'b0;
    end else begin
      pg_reg <= pg_next;
      idx_reg <= idx_next;
      tmr_reg <= tmr_next;
      busy <= busy_next;
      arm_reg <= arm_next;
      guard_reg <= guard_next;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      pend_s1 <= pend_reg;
      pend_s2 <= pend_s1;
    end
  end
endmodule : sewp_top
`default_nettype wire

// ===== verification/sewp_top_monitor.sv
/*
  checker on the ports of the serial eeprom block, bound into sewp_top at the foot.
  assumes: PROG_CYCLES matches the instance; sck runs only inside frames.
*/
`timescale 1ns/1ns
`default_nettype none
module sewp_top_monitor #(
  parameter int PROG_CYCLES = 100
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy
);
  int busy_cnt_reg;
  int busy_cnt_next;
  logic [5:0] rise_reg;
  logic [5:0] rise_next;
  always_comb busy_cnt_next = busy ? busy_cnt_reg + 1 : 0;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) busy_cnt_reg <= 0;
    else busy_cnt_reg <= busy_cnt_next;
  end
  // saturating rise count per frame; paused edges do not count
  always_comb rise_next = (rise_reg == 6'h3F) ? rise_reg : rise_reg + 6'h01;
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) rise_reg <= 6'h00;
    else if (hold_n) rise_reg <= rise_next;
  end
  oe_cs_idle_a: assert property (@(posedge mclk) disable iff (!rstn) cs_n |-> !so_oe)
    else $error("so driven while deselected");
  oe_hold_a: assert property (@(posedge mclk) disable iff (!rstn) !hold_n |-> !so_oe)
    else $error("so driven while paused");
  oe_after_opc_a: assert property (@(posedge mclk) disable iff (!rstn) so_oe |-> rise_reg >= 6'h08)
    else $error("so driven before a whole opcode");
  busy_len_a: assert property (@(posedge mclk) disable iff (!rstn) busy |-> busy_cnt_reg <= PROG_CYCLES)
    else $error("programming runs too long");
  busy_min_a: assert property (@(posedge mclk) disable iff (!rstn) $rose(busy) |-> busy[*8])
    else $error("busy pulse too short");
  busy_start_a: assert property (@(posedge mclk) disable iff (!rstn) $rose(busy) |-> cs_n)
    else $error("programming started inside a frame");
  busy_gap_a: assert property (@(posedge mclk) disable iff (!rstn) $fell(busy) |=> !busy[*8])
    else $error("programming restarted without new commands");
  busy_rst_a: assert property (@(posedge mclk) disable iff (!rstn) !$past(rstn) |-> !busy)
    else $error("busy high after reset");
endmodule : sewp_top_monitor
bind sewp_top sewp_top_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.mclk(mclk), .rstn(rstn),
  .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
  .busy(busy));
`default_nettype wire

// ===== verification/sewp_spi_master.sv
/*
  spi master model for the eeprom block: mode 0, sck still outside frames.
  assumes: the bench calls one task at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module sewp_spi_master (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  event rx_done;
  logic [7:0] rx_byte;
  // an undriven so reads as a toggling level, never a stale bit
  wire logic so_line = so_oe ? so : ~rx_byte[0];
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    rx_byte = 8'h00;
  end
  task automatic frame_open;
    cs_n = 1'b0;
    #15;
  endtask : frame_open
  // msb first, si moves with sck low, so taken on the rise
  task automatic xfer(input logic [7:0] tx, input bit chk);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #15 sck = 1'b1;
      rx_byte = {rx_byte[6:0], so_line};
      #15 sck = 1'b0;
    end
    if (chk) ->rx_done;
  endtask : xfer
  // pause entered and left with sck low; edges in between are ignored
  task automatic pause(input int n);
    #5 hold_n = 1'b0;
    repeat (n) begin
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
    #5 hold_n = 1'b1;
    #10;
  endtask : pause
  // deselect before any further rise, then idle longer than four mclk
  task automatic frame_close;
    #8 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask : frame_close
endmodule : sewp_spi_master
`default_nettype wire

// ===== verification/tb.sv
/*
  self-checking bench for sewp_top: master model on the link, wp_n from here.
  assumes: the defines header; a short programming time parameter.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sewp_defines.svh"
module tb;
  localparam int PROG = 100;
  logic mclk, rstn, sck, cs_n, si, hold_n, wp_n, so, so_oe, busy;
  int n_mismatch;
  int samples_checked;
  logic [7:0] exp_q[$];
  logic [7:0] mem[int];
  sewp_top #(.PROG_CYCLES(PROG)) u_dut (.mclk(mclk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy));
  sewp_spi_master u_m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // every byte received with the check flag set is matched against the oldest note
  initial forever begin
    @(u_m.rx_done);
    check("rx_byte", u_m.rx_byte, exp_q.pop_front());
  end
  // mode 0: no programming, 1: programming, 2: either
  task automatic wait_busy(input int mode);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (mode != 2) check("busy_seen", {7'h00, busy}, {7'h00, mode[0]});
    if (mode == 1 && busy !== 1'b1) close_out();
    n = 0;
    while (busy === 1'b1 && n < PROG + 20) begin
      @(negedge mclk);
      n++;
    end
    check("prog_len_ok", {7'h00, n <= PROG}, 8'h01);
    if (n >= PROG + 20) close_out();
  endtask : wait_busy
  task automatic cmd(input logic [7:0] op);
    u_m.frame_open();
    u_m.xfer(op, 0);
    u_m.frame_close();
  endtask : cmd
  // status byte repeats while selected
  task automatic sr_read(input logic [7:0] e);
    u_m.frame_open();
    u_m.xfer(`SEWP_OPC_SRD, 0);
    repeat (2) begin
      exp_q.push_back(e);
      u_m.xfer(8'($urandom), 1);
    end
    u_m.frame_close();
  endtask : sr_read
  task automatic sr_write(input logic [7:0] v, input int mode);
    cmd(`SEWP_OPC_ARM);
    u_m.frame_open();
    u_m.xfer(`SEWP_OPC_SWR, 0);
    u_m.xfer(v, 0);
    u_m.frame_close();
    wait_busy(mode);
  endtask : sr_write
  task automatic wr(input int a, input int n, input bit keep, input bit arm);
    logic [7:0] v;
    if (arm) cmd(`SEWP_OPC_ARM);
    u_m.frame_open();
    u_m.xfer(`SEWP_OPC_WRITE, 0);
    u_m.xfer(a[15:8], 0);
    u_m.xfer(a[7:0], 0);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      if (keep) mem[(a & 32'h0000_FFE0) + ((a + i) % 32)] = v;
      u_m.xfer(v, 0);
    end
    u_m.frame_close();
  endtask : wr
  // bit 3 of the opcode and top address bits are don't-care; si is noise after the address
  task automatic rd(input int a, input int n);
    u_m.frame_open();
    u_m.xfer(`SEWP_OPC_READ | 8'h08, 0);
    u_m.pause(3);
    u_m.xfer(8'hE0 | a[15:8], 0);
    u_m.xfer(a[7:0], 0);
    repeat (n) begin
      exp_q.push_back(mem[a]);
      u_m.xfer(8'($urandom), 1);
      a = (a + 1) % `SEWP_MEM_BYTES;
    end
    u_m.frame_close();
  endtask : rd
  initial begin
    bit prot;
    rstn = 1'b0;
    wp_n = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    void'($urandom(61001));
    repeat (12) @(posedge mclk);
    #2 rstn = 1'b1;
    sr_read(8'h00);
    $display("test reset done");
    // known contents at every probed spot, so a guarded write has something to spoil
    for (int i = 0; i < 16; i++) begin
      wr((i % 4) * 1024 + i / 4, 1, 1, 1);
      wait_busy(1);
    end
    for (int g = 0; g < 4; g++) begin
      sr_write({4'h0, g[1:0], 2'b00}, 1);
      sr_read({4'h0, g[1:0], 2'b00});
      for (int q = 0; q < 4; q++) begin
        prot = (g == 3) || (g == 2 && q >= 2) || (g == 1 && q == 3);
        wr(q * 1024 + g, 1, !prot, 1);
        wait_busy(prot ? 2 : 1);
      end
    end
    for (int g = 0; g < 4; g++) for (int q = 0; q < 4; q++) rd(q * 1024 + g, 1);
    $display("test guard done");
    sr_write(8'h80, 1);
    @(posedge mclk);
    #2 wp_n = 1'b0;
    sr_write(8'h8C, 0);
    sr_read(8'h80);
    wr(32'h0000_0FFE, 34, 1, 1);
    sr_read(8'hFF);
    cmd(`SEWP_OPC_ARM);
    wait_busy(1);
    sr_read(8'h80);
    @(posedge mclk);
    #2 wp_n = 1'b1;
    sr_write(8'h00, 1);
    wr(0, 1, 0, 0);
    wait_busy(0);
    cmd(`SEWP_OPC_ARM);
    sr_read(8'h02);
    cmd(`SEWP_OPC_DISARM);
    sr_read(8'h00);
    wr(0, 1, 0, 0);
    wait_busy(0);
    $display("test protect done");
    rd(32'h0000_0FE0, 32);
    rd(32'h0000_0FFF, 2);
    $display("test read done");
    close_out();
  end
endmodule : tb
`default_nettype wire
